// ### rtl/dps_defines.vh
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH
// register byte offsets
`define DPS_OFS_CTRL 8'h00
`define DPS_OFS_DIP 8'h04
`define DPS_OFS_ULOAD 8'h08
`define DPS_OFS_OSPD 8'h0C
`define DPS_OFS_GAP 8'h10
`define DPS_OFS_LOOP 8'h14
`define DPS_OFS_GAIN 8'h18
`define DPS_OFS_DERIV 8'h1C
`define DPS_OFS_STATUS 8'h20
`define DPS_OFS_DISP 8'h24
`define DPS_OFS_FREQ 8'h28
`define DPS_OFS_RANGE 8'h2C
// reset values; percentages in 0.1 % steps, times as noted
`define DPS_RST_CTRL 32'h0000_0000
`define DPS_RST_DIP 32'h0032_0320
`define DPS_RST_ULOAD 32'h000A_0064
`define DPS_RST_OSPD 32'h000A_0096
`define DPS_RST_GAP 32'h0032_00C8
`define DPS_RST_LOOP 32'h01F4_0000
`define DPS_RST_GAIN 32'h00C8_00C8
`define DPS_RST_DERIV 32'h0000_0000
`define DPS_RST_RANGE 32'h0000_03E8
// field positions
`define DPS_CTRL_DIPSEL 1:0
`define DPS_CTRL_ULEN 2
`define DPS_CTRL_LOOPEN 3
`define DPS_LO10 9:0
`define DPS_HI10 25:16
`define DPS_HI14 29:16
`define DPS_LOOP_TSRC 3:0
`define DPS_LOOP_FSRC 7:4
`define DPS_LOOP_DIR 8
// scale and codes
`define DPS_FULL 16'h03E8
`define DPS_UL_PCT 16'h0007
`define DPS_FAULT_GAP 8'h2A
`define DPS_FAULT_OSPD 8'h2B
`define DPS_TENTHS_TICKS 20'h0000A
// timing: 10 ms tick at 5 ns clock
`define DPS_TICK_NS 10000000
`define DPS_CLK_NS 5
`define DPS_TICK_CYCLES (`DPS_TICK_NS / `DPS_CLK_NS)
`endif

// ### rtl/dps_top.v
//Contract
// - dip mode 1: on supply dip lower output frequency and keep running.
// - mode 1 re-accelerates only after bus stays normal past recovery time.
// - dip mode 2: on supply dip decelerate until stopped.
// - underload enabled: low current past underload time drops frequency to 7% rated.
// - underload fallback returns to set frequency when load recovers; enable 0 off, 1 on.
// - overspeed and deviation checks only in sensor vector control.
// - speed above max plus margin past overspeed time raises fault 43.
// - overspeed time zero disables overspeed detection.
// - speed gap above margin past deviation time raises fault 42.
// - deviation time zero disables deviation detection.
// - target source: 0 value, 1-3 analog, 4 pulse, 5 comm, 6 multistep.
// - target is relative 0 to 100.0 %, default value 50.0 %.
// - feedback source: 0-2 analog, 3 diff, 4 pulse, 5 comm, 6 sum, 7 max, 8 min.
// - loop drives frequency so feedback equals target.
// - direction 0: low feedback raises frequency; 1: lowers it.
// - reverse input inverts the loop direction.
// - displays scale 100.0 % to the display range, default 1000.
// - gain set one defaults 20.0, 2.00 s, 0.000 s; gain sets swing per full deviation.
// - dip declared when bus below threshold, default 80.0 %.
// - recovery time defaults 0.50 s, range 0.00 to 100.00 s.
`timescale 1ns/100ps
`include "dps_defines.vh"

module dps_qual (
  input wire clk_i,
  input wire reset_i,
  input wire tick_i,
  input wire cond_i,
  input wire [19:0] limit_i,
  output wire hit_o
);
  reg [19:0] cnt_q;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 20'h00000;
    end else if (!cond_i) begin
      cnt_q <= 20'h00000;
    end else if (tick_i && cnt_q != 20'hFFFFF) begin
      cnt_q <= cnt_q + 20'h00001;
    end
  end
  assign hit_o = cond_i && (cnt_q > limit_i);
endmodule // dps_qual

module dps_top #(
  parameter TICK_CYCLES = `DPS_TICK_CYCLES,
  parameter RAMP_STEP = 16'h0001
) (
  input wire clk_i,
  input wire reset_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire run_i,
  input wire sensor_vector_i,
  input wire loop_reverse_i,
  input wire [15:0] bus_voltage_i,
  input wire [15:0] current_i,
  input wire [15:0] speed_actual_i,
  input wire [15:0] freq_set_i,
  input wire [15:0] rated_freq_i,
  input wire [15:0] analog_in_one_i,
  input wire [15:0] analog_in_two_i,
  input wire [15:0] analog_in_three_i,
  input wire [15:0] pulse_capable_input_i,
  input wire [15:0] comm_value_i,
  input wire [15:0] multistep_value_i,
  output wire [15:0] freq_cmd_o,
  output wire fault_o,
  output wire [7:0] fault_code_o
);
  reg [31:0] ctrl_q;
  reg [31:0] dip_q;
  reg [31:0] uload_q;
  reg [31:0] ospd_q;
  reg [31:0] gap_q;
  reg [31:0] loop_q;
  reg [31:0] gain_q;
  reg [31:0] deriv_q;
  reg [31:0] range_q;
  reg [15:0] freq_q;
  reg [7:0] fault_q;
  reg dip_hold_q;
  reg dip_stop_q;
  reg ul_active_q;
  reg [31:0] tick_cnt_q;
  reg tick_q;
  reg [15:0] icnt_q;
  reg signed [17:0] integ_q;
  reg [15:0] fb_prev_q;
  reg [15:0] tgt_disp_q;
  reg [15:0] fb_disp_q;

  wire access = psel && penable && !pready;
  wire wr_done = psel && penable && pready && pwrite;
  wire [1:0] dip_sel = ctrl_q[`DPS_CTRL_DIPSEL];

  // fixed time base shared by all duration qualifiers
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_CYCLES - 1);
      tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    end
  end

  // threshold tests
  wire dip_now = bus_voltage_i < {6'h00, dip_q[`DPS_LO10]};
  wire bus_ok = bus_voltage_i > {6'h00, dip_q[`DPS_LO10]};
  wire ul_cond = ctrl_q[`DPS_CTRL_ULEN] && run_i && current_i < {6'h00, uload_q[`DPS_LO10]};
  wire [16:0] os_lim = {1'b0, `DPS_FULL} + {7'h00, ospd_q[`DPS_LO10]};
  wire os_cond = sensor_vector_i && ospd_q[`DPS_HI10] != 10'h000
    && {1'b0, speed_actual_i} > os_lim;
  wire [15:0] gap_abs = (speed_actual_i > freq_set_i) ? speed_actual_i - freq_set_i : freq_set_i - speed_actual_i;
  wire gap_cond = sensor_vector_i && gap_q[`DPS_HI10] != 10'h000
    && gap_abs > {6'h00, gap_q[`DPS_LO10]};

  wire rec_hit;
  wire ul_hit;
  wire os_hit;
  wire gap_hit;
  wire [19:0] ul_lim = uload_q[`DPS_HI10] * `DPS_TENTHS_TICKS;
  wire [19:0] os_tlim = ospd_q[`DPS_HI10] * `DPS_TENTHS_TICKS;
  wire [19:0] gap_tlim = gap_q[`DPS_HI10] * `DPS_TENTHS_TICKS;
  dps_qual u_rec (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick_q),
    .cond_i(bus_ok && dip_hold_q),
    .limit_i({6'h00, dip_q[`DPS_HI14]}),
    .hit_o(rec_hit)
  );
  dps_qual u_ul (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick_q),
    .cond_i(ul_cond),
    .limit_i(ul_lim),
    .hit_o(ul_hit)
  );
  dps_qual u_os (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick_q),
    .cond_i(os_cond),
    .limit_i(os_tlim),
    .hit_o(os_hit)
  );
  dps_qual u_gap (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick_q),
    .cond_i(gap_cond),
    .limit_i(gap_tlim),
    .hit_o(gap_hit)
  );

  // loop target and feedback selection
  reg [15:0] tgt, fb;
  always @* begin
    case (loop_q[`DPS_LOOP_TSRC])
      4'h0: tgt = {6'h00, loop_q[`DPS_HI10]};
      4'h1: tgt = analog_in_one_i;
      4'h2: tgt = analog_in_two_i;
      4'h3: tgt = analog_in_three_i;
      4'h4: tgt = pulse_capable_input_i;
      4'h5: tgt = comm_value_i;
      4'h6: tgt = multistep_value_i;
      default: tgt = 16'h0000;
    endcase
    case (loop_q[`DPS_LOOP_FSRC])
      4'h0: fb = analog_in_one_i;
      4'h1: fb = analog_in_two_i;
      4'h2: fb = analog_in_three_i;
      4'h3: fb = (analog_in_one_i > analog_in_two_i) ? analog_in_one_i - analog_in_two_i : 16'h0000;
      4'h4: fb = pulse_capable_input_i;
      4'h5: fb = comm_value_i;
      4'h6: fb = analog_in_one_i + analog_in_two_i;
      4'h7: fb = (analog_in_one_i > analog_in_two_i) ? analog_in_one_i : analog_in_two_i;
      4'h8: fb = (analog_in_one_i < analog_in_two_i) ? analog_in_one_i : analog_in_two_i;
      default: fb = 16'h0000;
    endcase
    // relative quantities stop at 100.0 %
    if (tgt > `DPS_FULL) tgt = `DPS_FULL;
    if (fb > `DPS_FULL) fb = `DPS_FULL;
  end

  // error sign follows the action direction, flipped by the reverse input
  wire rev = loop_q[`DPS_LOOP_DIR] ^ loop_reverse_i;
  wire signed [17:0] err_raw = $signed({2'b00, tgt}) - $signed({2'b00, fb});
  wire signed [17:0] err = rev ? -err_raw : err_raw;
  // proportional: gain 100.0 gives one full scale of frequency per full scale of error
  wire signed [31:0] p_term = (err * $signed({22'h000000, gain_q[`DPS_LO10]})) / 32'sd1000;
  wire signed [17:0] dfb = $signed({2'b00, fb_prev_q}) - $signed({2'b00, fb});
  wire signed [31:0] d_raw = (dfb * $signed({18'h00000, deriv_q[13:0]})) / 32'sd10;
  wire signed [31:0] d_term = rev ? -d_raw : d_raw;
  wire signed [31:0] pid_sum = p_term + {{14{integ_q[17]}}, integ_q} + d_term;
  wire [15:0] pid_out = pid_sum < 0 ? 16'h0000 : (pid_sum > 32'sd1000 ? `DPS_FULL : pid_sum[15:0]);

  // integral: one full error adds one full scale after one integral time
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      icnt_q <= 16'h0000;
      integ_q <= 18'sh00000;
      fb_prev_q <= 16'h0000;
    end else if (!run_i || !ctrl_q[`DPS_CTRL_LOOPEN]) begin
      icnt_q <= 16'h0000;
      integ_q <= 18'sh00000;
      fb_prev_q <= fb;
    end else if (tick_q) begin
      fb_prev_q <= fb;
      if (icnt_q + 16'h0001 >= {6'h00, gain_q[`DPS_HI10]}) begin
        icnt_q <= 16'h0000;
        if (integ_q + err > 18'sd1000) integ_q <= 18'sd1000;
        else if (integ_q + err < -18'sd1000) integ_q <= -18'sd1000;
        else integ_q <= integ_q + err;
      end else begin
        icnt_q <= icnt_q + 16'h0001;
      end
    end
  end

  // frequency command
  wire [31:0] ul_mul = rated_freq_i * `DPS_UL_PCT;
  wire [31:0] ul_div = ul_mul / 32'd100;
  wire [15:0] ul_freq = ul_div[15:0];
  wire [15:0] base = !run_i ? 16'h0000 : (ctrl_q[`DPS_CTRL_LOOPEN] ? pid_out : freq_set_i);
  wire [15:0] goal = (dip_stop_q || !run_i) ? 16'h0000 : (ul_active_q ? ul_freq : base);
  wire [15:0] down = freq_q > RAMP_STEP ? freq_q - RAMP_STEP : 16'h0000;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      freq_q <= 16'h0000;
      dip_hold_q <= 1'b0;
      dip_stop_q <= 1'b0;
      ul_active_q <= 1'b0;
    end else begin
      if (!run_i) begin
        dip_stop_q <= 1'b0;
        dip_hold_q <= 1'b0;
      end else if (dip_now && dip_sel == 2'd2) begin
        dip_stop_q <= 1'b1;
      end else if (dip_now && dip_sel == 2'd1) begin
        dip_hold_q <= 1'b1;
      end else if (rec_hit) begin
        dip_hold_q <= 1'b0;
      end
      if (ul_hit) begin
        ul_active_q <= 1'b1;
      end else if (!ul_cond) begin
        ul_active_q <= 1'b0;
      end
      if (tick_q) begin
        if (dip_hold_q && dip_now) begin
          freq_q <= down;
        end else if (dip_hold_q) begin
          freq_q <= freq_q; // hold until recovery qualifies
        end else if (freq_q > goal) begin
          freq_q <= (freq_q - goal > RAMP_STEP) ? freq_q - RAMP_STEP : goal;
        end else if (goal - freq_q > RAMP_STEP) begin
          freq_q <= freq_q + RAMP_STEP;
        end else begin
          freq_q <= goal;
        end
      end
    end
  end
  assign freq_cmd_o = freq_q;

  // fault latch: a new fault wins over a software clear in the same cycle
  wire clr_fault = wr_done && paddr == `DPS_OFS_STATUS && pwdata[0];
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_q <= 8'h00;
    end else if (os_hit && fault_q == 8'h00) begin
      fault_q <= `DPS_FAULT_OSPD;
    end else if (gap_hit && fault_q == 8'h00) begin
      fault_q <= `DPS_FAULT_GAP;
    end else if (clr_fault && !os_hit && !gap_hit) begin
      fault_q <= 8'h00;
    end
  end
  assign fault_o = fault_q != 8'h00;
  assign fault_code_o = fault_q;

  // display scaling: 100.0 % shows as the display range
  wire [31:0] tgt_mul = tgt * range_q[15:0];
  wire [31:0] fb_mul = fb * range_q[15:0];
  wire [31:0] tgt_div = tgt_mul / 32'd1000;
  wire [31:0] fb_div = fb_mul / 32'd1000;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tgt_disp_q <= 16'h0000;
      fb_disp_q <= 16'h0000;
    end else begin
      tgt_disp_q <= tgt_div[15:0];
      fb_disp_q <= fb_div[15:0];
    end
  end

  // apb slave: one wait state so read data comes from a flop
  reg [31:0] rd;
  reg hit;
  always @* begin
    hit = 1'b1;
    case (paddr)
      `DPS_OFS_CTRL: rd = {28'h0000000, ctrl_q[3:0]};
      `DPS_OFS_DIP: rd = {2'b00, dip_q[29:16], 6'h00, dip_q[9:0]};
      `DPS_OFS_ULOAD: rd = {6'h00, uload_q[25:16], 6'h00, uload_q[9:0]};
      `DPS_OFS_OSPD: rd = {6'h00, ospd_q[25:16], 6'h00, ospd_q[9:0]};
      `DPS_OFS_GAP: rd = {6'h00, gap_q[25:16], 6'h00, gap_q[9:0]};
      `DPS_OFS_LOOP: rd = {6'h00, loop_q[25:16], 7'h00, loop_q[8:0]};
      `DPS_OFS_GAIN: rd = {6'h00, gain_q[25:16], 6'h00, gain_q[9:0]};
      `DPS_OFS_DERIV: rd = {18'h00000, deriv_q[13:0]};
      `DPS_OFS_STATUS: rd = {16'h0000, fault_q, 3'h0, ul_active_q, dip_stop_q, dip_hold_q, dip_now, fault_o};
      `DPS_OFS_DISP: rd = {fb_disp_q, tgt_disp_q};
      `DPS_OFS_FREQ: rd = {16'h0000, freq_q};
      `DPS_OFS_RANGE: rd = {16'h0000, range_q[15:0]};
      default: begin
        rd = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && !hit;
      if (access && !pwrite) prdata <= rd;
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= `DPS_RST_CTRL;
      dip_q <= `DPS_RST_DIP;
      uload_q <= `DPS_RST_ULOAD;
      ospd_q <= `DPS_RST_OSPD;
      gap_q <= `DPS_RST_GAP;
      loop_q <= `DPS_RST_LOOP;
      gain_q <= `DPS_RST_GAIN;
      deriv_q <= `DPS_RST_DERIV;
      range_q <= `DPS_RST_RANGE;
    end else if (wr_done) begin
      case (paddr)
        `DPS_OFS_CTRL: ctrl_q <= pwdata;
        `DPS_OFS_DIP: dip_q <= pwdata;
        `DPS_OFS_ULOAD: uload_q <= pwdata;
        `DPS_OFS_OSPD: ospd_q <= pwdata;
        `DPS_OFS_GAP: gap_q <= pwdata;
        `DPS_OFS_LOOP: loop_q <= pwdata;
        `DPS_OFS_GAIN: gain_q <= pwdata;
        `DPS_OFS_DERIV: deriv_q <= pwdata;
        `DPS_OFS_RANGE: range_q <= pwdata;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end
endmodule // dps_top

// ### test/dps_chk.sv
`timescale 1ns/100ps
module dps_chk (
  input wire clk_i,
  input wire reset_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sensor_vector_i,
  input wire [15:0] freq_cmd_o,
  input wire fault_o,
  input wire [7:0] fault_code_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  a_ready_follows: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (psel && penable && pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h2C))
    else $error("slave error does not match decode");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_code_legal: assert property (fault_code_o == 8'h00 || fault_code_o == 8'h2A || fault_code_o == 8'h2B)
    else $error("illegal fault code");
  a_fault_level: assert property (fault_o == (fault_code_o != 8'h00))
    else $error("fault flag and code disagree");
  a_fault_gated: assert property ($rose(fault_o) |-> $past(sensor_vector_i))
    else $error("speed fault without sensor vector mode");
  a_code_stable: assert property (fault_o && $past(fault_o) |-> $stable(fault_code_o))
    else $error("latched fault code changed");
  a_fault_clear: assert property ($fell(fault_o) |-> $past(psel && penable && pready && pwrite && paddr == 8'h20 && pwdata[0]))
    else $error("fault dropped without clear write");
  a_quiet_reset: assert property ($fell(reset_i) |-> freq_cmd_o == 16'h0000 && fault_code_o == 8'h00 && !pready)
    else $error("outputs not idle after reset");
  a_freq_clamp: assert property (freq_cmd_o <= 16'h03E8)
    else $error("frequency command above full scale");
endmodule // dps_chk

bind dps_top dps_chk chk_u (.clk_i(clk_i), .reset_i(reset_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sensor_vector_i(sensor_vector_i), .freq_cmd_o(freq_cmd_o), .fault_o(fault_o), .fault_code_o(fault_code_o));

// ### test/dps_plant.sv
`timescale 1ns/100ps
module dps_plant (
  input wire clk_i,
  input wire [15:0] freq_cmd_i,
  input wire [15:0] slip_i,
  input wire dip_i,
  output wire [15:0] speed_o,
  output wire [15:0] bus_o
);
  logic [15:0] spd_q = 16'h0000;
  // shaft lags the command by a clock; the offset stands for load or runaway
  always @(posedge clk_i) spd_q <= freq_cmd_i + slip_i;
  assign speed_o = spd_q;
  // a dip pulls the bus to 70 % of standard, below the default threshold
  assign bus_o = dip_i ? 16'h02BC : 16'h03E8;
endmodule // dps_plant

// ### test/drive_protection_and_pid_setup_test.sv
`timescale 1ns/100ps
`include "dps_defines.vh"
module drive_protection_and_pid_setup_test;
  localparam int TK = 20;
  logic clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, run = 0, sv = 0, rev = 0, dip = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic [15:0] fset = 16'h0000, cur = 16'h01F4, slip = 16'h0000, spd, bus, freq;
  logic pready, pslverr, fault;
  logic [7:0] code;
  logic [15:0] rated = 16'h03E8, a1 = 16'h012C, a2 = 16'h00C8, a3 = 16'h0064;
  int n_errors = 0, check_count = 0, cyc = 0;
  logic [7:0] ofs_t [9] = '{`DPS_OFS_CTRL, `DPS_OFS_DIP, `DPS_OFS_ULOAD, `DPS_OFS_OSPD, `DPS_OFS_GAP,
    `DPS_OFS_LOOP, `DPS_OFS_GAIN, `DPS_OFS_DERIV, `DPS_OFS_RANGE};
  logic [31:0] rst_t [9] = '{`DPS_RST_CTRL, `DPS_RST_DIP, `DPS_RST_ULOAD, `DPS_RST_OSPD, `DPS_RST_GAP,
    `DPS_RST_LOOP, `DPS_RST_GAIN, `DPS_RST_DERIV, `DPS_RST_RANGE};
  logic [15:0] tg_t [9] = '{16'h03E8, 16'h0258, 16'h0190, 16'h00C8, 16'h0320, 16'h04B0, 16'h0578, 16'h03E8, 16'h03E8};
  logic [15:0] fb_t [9] = '{16'h0258, 16'h0190, 16'h00C8, 16'h00C8, 16'h0320, 16'h04B0, 16'h03E8, 16'h0258, 16'h0190};
  always #2.5 clk_i = ~clk_i;
  dps_plant plant_u (.clk_i(clk_i), .freq_cmd_i(freq), .slip_i(slip), .dip_i(dip), .speed_o(spd), .bus_o(bus));
  dps_top #(.TICK_CYCLES(TK), .RAMP_STEP(16'h0064)) dut_u (.clk_i(clk_i), .reset_i(reset_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .run_i(run), .sensor_vector_i(sv), .loop_reverse_i(rev), .bus_voltage_i(bus),
    .current_i(cur), .speed_actual_i(spd), .freq_set_i(fset), .rated_freq_i(rated),
    .analog_in_one_i(a1), .analog_in_two_i(a2), .analog_in_three_i(a3),
    .pulse_capable_input_i(16'h0190), .comm_value_i(16'h0258), .multistep_value_i(16'h02BC),
    .freq_cmd_o(freq), .fault_o(fault), .fault_code_o(code));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  // pready is a flop, so reading it right after the edge gives the sampled value
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk_i);
  endtask
  task automatic wt(input logic s, input logic [15:0] v, input int n);
    int k;
    k = 0;
    while ((s ? {8'h00, code} : freq) !== v && k < n * TK) begin
      @(posedge clk_i);
      k++;
    end
    chk({16'h0000, s ? {8'h00, code} : freq}, {16'h0000, v}, s ? "fault code" : "frequency");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ofs_t[i], 32'h0000_0000);
      chk(rd, rst_t[i], "reset value");
    end
    apb(1'b1, 8'h30, 32'h0000_00FF);
    chk({31'h0, er}, 32'h1, "unmapped write error");
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk({31'h0, er}, 32'h1, "unmapped read error");
    chk(rd, 32'h0000_0000, "unmapped read data");
    $display("test regs done");
  endtask
  task automatic t_faults();
    sv <= 1'b1;
    slip <= 16'h04B0;
    apb(1'b1, `DPS_OFS_OSPD, 32'h0000_0096);
    ticks(30);
    wt(1'b1, 16'h0000, 0);
    sv <= 1'b0;
    apb(1'b1, `DPS_OFS_OSPD, 32'h0001_0096);
    ticks(30);
    wt(1'b1, 16'h0000, 0);
    sv <= 1'b1;
    ticks(9);
    wt(1'b1, 16'h0000, 0);
    wt(1'b1, 16'h002B, 6);
    chk({31'h0, fault}, 32'h1, "fault flag");
    slip <= 16'h047E;
    ticks(2);
    apb(1'b1, `DPS_OFS_STATUS, 32'h0000_0001);
    ticks(20);
    wt(1'b1, 16'h0000, 0);
    apb(1'b1, `DPS_OFS_GAP, 32'h0000_00C8);
    slip <= 16'h012C;
    ticks(30);
    wt(1'b1, 16'h0000, 0);
    slip <= 16'h00C8;
    apb(1'b1, `DPS_OFS_GAP, 32'h0001_00C8);
    ticks(30);
    wt(1'b1, 16'h0000, 0);
    slip <= 16'h012C;
    ticks(9);
    wt(1'b1, 16'h0000, 0);
    wt(1'b1, 16'h002A, 6);
    chk({31'h0, fault}, 32'h1, "fault flag");
    slip <= 16'h0000;
    ticks(2);
    apb(1'b1, `DPS_OFS_STATUS, 32'h0000_0001);
    sv <= 1'b0;
    ticks(1);
    $display("test faults done");
  endtask
  task automatic t_uload();
    run <= 1'b1;
    fset <= 16'h01F4;
    rated <= 16'h07D0;
    apb(1'b1, `DPS_OFS_ULOAD, 32'h0001_0064);
    apb(1'b1, `DPS_OFS_CTRL, 32'h0000_0004);
    wt(1'b0, 16'h01F4, 20);
    cur <= 16'h0064;
    ticks(20);
    wt(1'b0, 16'h01F4, 0);
    cur <= 16'h0032;
    ticks(9);
    wt(1'b0, 16'h01F4, 0);
    wt(1'b0, 16'h008C, 20);
    cur <= 16'h01F4;
    wt(1'b0, 16'h01F4, 20);
    apb(1'b1, `DPS_OFS_CTRL, 32'h0000_0000);
    cur <= 16'h0032;
    ticks(20);
    wt(1'b0, 16'h01F4, 0);
    cur <= 16'h01F4;
    $display("test underload done");
  endtask
  task automatic t_dip();
    logic [15:0] h;
    apb(1'b1, `DPS_OFS_DIP, 32'h0005_0320);
    apb(1'b1, `DPS_OFS_CTRL, 32'h0000_0001);
    dip <= 1'b1;
    ticks(3);
    chk({31'h0, freq < 16'h01F4}, 32'h1, "dip slows");
    dip <= 1'b0;
    ticks(1);
    h = freq;
    ticks(3);
    wt(1'b0, h, 0);
    wt(1'b0, 16'h01F4, 20);
    apb(1'b1, `DPS_OFS_CTRL, 32'h0000_0002);
    dip <= 1'b1;
    wt(1'b0, 16'h0000, 20);
    dip <= 1'b0;
    ticks(10);
    wt(1'b0, 16'h0000, 0);
    run <= 1'b0;
    ticks(2);
    $display("test dip done");
  endtask
  task automatic t_loop();
    apb(1'b1, `DPS_OFS_RANGE, 32'h0000_07D0);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, `DPS_OFS_LOOP, {16'h01F4, 8'h00, i[3:0], (i > 6) ? 4'h0 : i[3:0]});
      ticks(2);
      apb(1'b0, `DPS_OFS_DISP, 32'h0000_0000);
      chk(rd, {fb_t[i], tg_t[i]}, "loop display");
    end
    apb(1'b1, `DPS_OFS_LOOP, 32'h01F4_0100);
    apb(1'b1, `DPS_OFS_CTRL, 32'h0000_0008);
    run <= 1'b1;
    ticks(30);
    wt(1'b0, 16'h0000, 0);
    rev <= 1'b1;
    ticks(30);
    // 20 % error at gain 20.0 asks for 4 % of full scale; integral has not stepped yet
    wt(1'b0, 16'h0028, 0);
    $display("test loop done");
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      $display("wrong value at %0t: run took too long", $time);
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_faults();
    t_uload();
    t_dip();
    t_loop();
    print_verdict();
  end
endmodule // drive_protection_and_pid_setup_test
